// ===== readout_trigger_generator_tb.sv
// Self-checking bench of the readout trigger generator.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module readout_trigger_generator_tb;
    import rtg_pkg::*;
    logic clk, rst_n, busy, trg_inhibit, stall, tbl_wr, tbl_commit;
    logic word_strobe, collision, evt_valid, active_bank;
    logic [6:0]       stretch_cyc, inhibit_cyc;
    logic [2:0][7:0]  prescale;
    rtg_psel_t [3:0]  psel;
    logic [23:0]      tbl_addr;
    logic [31:0]      tbl_data;
    logic [15:0]      trig_word, w, lfsr;
    rtg_prim_t        prim_in, pr;
    rtg_evt_t         evt;
    rtg_pevt_t [3:0]  pevt;
    rtg_stat_t        stat, s0;
    logic [1:0]       fe_act, ph, q;
    logic [11:0]      fe_part;
    logic [21:0]      ex;
    int               err_count, checked, cyc, nev, ncol;

    rtg_top dut (.clk(clk), .rst_n(rst_n), .prim_in(prim_in), .busy(busy), .trg_inhibit(trg_inhibit),
        .stretch_cyc(stretch_cyc), .inhibit_cyc(inhibit_cyc), .prescale(prescale), .psel(psel),
        .tbl_wr(tbl_wr), .tbl_addr(tbl_addr), .tbl_data(tbl_data), .tbl_commit(tbl_commit),
        .trig_word(trig_word), .word_strobe(word_strobe), .collision(collision), .evt(evt),
        .evt_valid(evt_valid), .pevt(pevt), .stat(stat), .active_bank(active_bank));
    rtg_fe_model fe (.clk(clk), .rst_n(rst_n), .trig_word(trig_word), .word_strobe(word_strobe),
        .stall(stall), .busy(busy), .act(fe_act), .part(fe_part));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    // Index the table sees: the 75 levels folded in 10-bit chunks.
    function automatic logic [9:0] fold_exp(input rtg_prim_t p);
        logic [79:0] v;
        logic [9:0]  f;
        v = {5'h00, p};
        f = 10'h000;
        for (int k = 0; k < 8; k++)
            f ^= v[k*10 +: 10];
        return f;
    endfunction : fold_exp
    // Entry 1 requests nothing, so a lone first primitive only feeds partitions.
    // Entries with action 11 are held in type B alone, so both word headers go out.
    function automatic logic [21:0] tbl_exp(input logic [9:0] i);
        if (i == 10'h001)
            return 22'h000000;
        if (i[9:8] == 2'h3)
            return {1'b0, i, 11'h000};
        return {12'h000, (i[9:8] == 2'h0) ? 2'h1 : i[9:8], i[7:0]};
    endfunction : tbl_exp
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        @(negedge clk);
        tbl_wr = 1'b1;
        tbl_addr = a;
        tbl_data = d;
    endtask : wr
    task automatic commit();
        @(negedge clk);
        tbl_wr = 1'b0;
        tbl_commit = 1'b1;
        @(negedge clk);
        tbl_commit = 1'b0;
    endtask : commit
    task automatic fire(input rtg_prim_t p);
        @(negedge clk);
        prim_in = p;
        q = ph + 2'h3;
        @(negedge clk);
        prim_in = '0;
    endtask : fire
    // Counts accepted events and collisions over a fixed span, keeping the word of the last accepted event.
    task automatic watch(input int n);
        nev = 0;
        ncol = 0;
        repeat (n)
        begin
            @(negedge clk);
            if (evt_valid === 1'b1)
            begin
                nev++;
                w = trig_word;
            end
            if (collision === 1'b1)
                ncol++;
        end
    endtask : watch
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Slot phase seen from outside: a word strobe marks the cycle after the slot closes.
    always @(negedge clk)
        ph <= (word_strobe === 1'b1) ? 2'h2 : ph + 2'h1;
    // The table load dominates the run; the ceiling leaves ample margin above it.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        prim_in = '0; stall = 0; trg_inhibit = 0; tbl_wr = 0; tbl_commit = 0;
        // The table is read from the levels at slot close, so the stretch spans a whole slot.
        tbl_addr = '0; tbl_data = '0; stretch_cyc = 7'h04; inhibit_cyc = 7'h28;
        prescale = '0; lfsr = 16'h992A; rst_n = 0; w = '0;
        for (int p = 0; p < 4; p++)
            psel[p] = {12'hFFF, 25'h1FFFFFF, 25'h1FFFFE0};
        repeat (2) @(posedge clk);
        @(negedge clk) rst_n = 1;
        watch(2);
        nev = 0;
        repeat (12) begin @(negedge clk); if (word_strobe === 1'b1) nev++; end
        `CHK(nev, 3)
        `CHK(trig_word[15:12], 4'h4)
        for (int i = 0; i < 1024; i++) wr(24'(i), {10'h000, tbl_exp(10'(i))});
        for (int i = 0; i < 32768; i++) wr({4'(i / 8192 + 1), 20'(i % 8192)}, 32'(i / 8192 + 1));
        commit();
        `CHK(active_bank, 1'b1)
        // Random patterns: word type and action follow the table, the quarter follows the firing phase.
        repeat (20)
        begin
            for (int k = 0; k < 5; k++) begin lfsr = lfsr_next(lfsr); pr = {pr[59:0], lfsr[14:0]}; end
            if (fold_exp(pr) == 10'h001)
                pr.proc[1] = ~pr.proc[1];
            ex = tbl_exp(fold_exp(pr));
            if (ex[9:8] == 2'h0)
                ex[10:0] = {1'b1, ex[20:11]};
            fire(pr);
            watch(60);
            `CHK(nev, 1)
            `CHK(w[15:12], ex[10] ? 4'hA : 4'h9)
            `CHK({w[9:0], evt.etype[9:0], evt.src_b}, {ex[9:0], ex[9:0], ex[10]})
            `CHK(fe_act, ex[9:8])
            `CHK({w[11:10], evt.quad}, {q, q})
        end
        // A second edge inside the inhibit window is vetoed.
        fire(75'h4);
        watch(10);
        fire(75'h4);
        watch(60);
        `CHK(ncol > 0, 1'b1)
        `CHK(nev, 0)
        // Busy, then inhibit: no event goes out, dead time runs and live time stops.
        for (int b = 0; b < 2; b++)
        begin
            stall = (b == 0);
            trg_inhibit = (b == 1);
            watch(8);
            s0 = stat;
            fire(75'h4);
            watch(40);
            `CHK(nev, 0)
            `CHK(ncol > 0, 1'b1)
            `CHK(stat.dead - s0.dead, 32'd42)
            `CHK(stat.live, s0.live)
            stall = 0;
            trg_inhibit = 0;
            watch(60);
            `CHK(stat.live != s0.live, 1'b1)
        end
        // Lone partition input: one partition word, each field in its place.
        fire(75'h1);
        watch(60);
        `CHK(nev, 0)
        `CHK(fe_part, 12'h8D1)
        for (int p = 0; p < 4; p++)
            `CHK({pevt[p].count, pevt[p].etype}, {32'h1, 3'(p + 1)})
        // Main and partition in one slot: the main word wins, partitions are dropped.
        s0 = stat;
        fire(75'h3);
        watch(60);
        `CHK(w[15:12], 4'h9)
        `CHK(stat.part_lost != s0.part_lost, 1'b1)
        // New entry waits in the idle bank until the commit; its type B loses to type A.
        wr(24'h000003, 32'h00082AAA);
        @(negedge clk) tbl_wr = 1'b0;
        fire(75'h3);
        watch(60);
        `CHK(w[9:0], tbl_exp(10'h003))
        commit();
        fire(75'h3);
        watch(60);
        `CHK(w[9:0], 10'h2AA)
        `CHK({ncol, stat.lost - s0.lost}, {32'h1, 32'h1})
        `CHK(active_bank, 1'b0)
        stop_test();
    end
endmodule : readout_trigger_generator_tb

// ===== rtg_fe_model.sv
// Frontend receiver model that decodes the trigger word stream.
`timescale 1ns/1ps
module rtg_fe_model
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Word stream and local buffer state.
    input  wire logic [15:0] trig_word,
    input  wire logic        word_strobe,
    input  wire logic        stall,
    output logic             busy,
    // Decoded results.
    output logic [1:0]       act,
    output logic [11:0]      part
);
    // Busy is a plain level, raised while the local buffers are full.
    assign busy = stall;
    // Only strobe words change what the receiver holds; time words just pass.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act  <= 2'h0;
            part <= 12'h000;
        end
        else if (word_strobe && (trig_word[15:12] == 4'h9 || trig_word[15:12] == 4'hA))
            act <= trig_word[9:8];
        else if (word_strobe && trig_word[15:12] == 4'hB)
            part <= trig_word[11:0];
    end
endmodule : rtg_fe_model

// ===== rtg_params.svh
// Constants of the readout trigger generator: timing, word headers and table map.
`ifndef RTG_PARAMS_SVH
`define RTG_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define RTG_CLK_PERIOD_NS 5
`define RTG_WIN_MIN_NS    8
`define RTG_WIN_MAX_NS    500
`define RTG_WIN_MIN_CYC   ((`RTG_WIN_MIN_NS + `RTG_CLK_PERIOD_NS - 1) / `RTG_CLK_PERIOD_NS)
`define RTG_WIN_MAX_CYC   (`RTG_WIN_MAX_NS / `RTG_CLK_PERIOD_NS)

// ****************************************************************
// Word headers in bits 15:12 and the receiver action field
// ****************************************************************
`define RTG_HDR_TIME  4'h4
`define RTG_HDR_TRG_A 4'h9
`define RTG_HDR_TRG_B 4'hA
`define RTG_HDR_PART  4'hB
`define RTG_ACT_NONE  2'h0

// ****************************************************************
// Table write map, selected by write address bits 23:20
// ****************************************************************
`define RTG_SEL_MAIN  4'h0
`define RTG_SEL_P1    4'h1
`define RTG_SEL_P4    4'h4

`endif

// ===== rtg_pkg.sv
// Types and shared functions of the readout trigger generator.
package rtg_pkg;
`include "rtg_params.svh"

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // All 75 primitives: 15 asynchronous, 30 external, 30 processor.
    typedef struct packed {
        logic [14:0] asy;
        logic [29:0] ext;
        logic [29:0] proc;
    } rtg_prim_t;

    // Input choice of one partition: indices into each group.
    typedef struct packed {
        logic [2:0][3:0] asy;
        logic [4:0][4:0] ext;
        logic [4:0][4:0] proc;
    } rtg_psel_t;

    typedef struct packed {
        logic [31:0] live;
        logic [31:0] dead;
        logic [31:0] lost;
        logic [31:0] part_lost;
    } rtg_stat_t;

    // Per-event record of the main generator.
    typedef struct packed {
        logic [31:0] number;
        logic [13:0] time_tag;
        logic [1:0]  quad;
        logic [10:0] etype;
        logic        src_b;
    } rtg_evt_t;

    // Per-partition event record.
    typedef struct packed {
        logic [31:0] count;
        logic [2:0]  etype;
    } rtg_pevt_t;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Window lengths are held inside the programmable range.
    function automatic logic [6:0] rtg_clamp(input logic [6:0] v);
        if (v < 7'(`RTG_WIN_MIN_CYC))
            return 7'(`RTG_WIN_MIN_CYC);
        if (v > 7'(`RTG_WIN_MAX_CYC))
            return 7'(`RTG_WIN_MAX_CYC);
        return v;
    endfunction : rtg_clamp

    // The 75 primitive levels are folded to the 10-bit table index.
    function automatic logic [9:0] rtg_fold(input rtg_prim_t p);
        logic [79:0] v;
        logic [9:0]  f;
        v = {5'h00, p};
        f = 10'h000;
        for (int k = 0; k < 8; k++)
            f = f ^ v[k*10 +: 10];
        return f;
    endfunction : rtg_fold

endpackage : rtg_pkg

// ===== rtg_stretch.sv
// Synchroniser, stretcher and prescaler for one trigger primitive.
`timescale 1ns/1ps
module rtg_stretch
    import rtg_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Primitive pin and settings.
    input  wire logic       din,
    input  wire logic [6:0] len,
    input  wire logic [7:0] prescale,
    // Stretched level and accepted edge.
    output logic            level,
    output logic            rise
);

    logic       s1, s2, s3;
    logic [7:0] pcnt, next_pcnt;
    logic [6:0] cnt, next_cnt;
    logic       next_rise;

    // A prescale of N passes one edge in N+1; zero passes every edge.
    always_comb
    begin
        next_pcnt = pcnt;
        next_cnt  = (cnt != 7'h00) ? cnt - 7'h01 : 7'h00;
        next_rise = 1'b0;
        if (s2 && !s3)
        begin
            if (pcnt >= prescale)
            begin
                next_pcnt = 8'h00;
                next_cnt  = len;                       // R1
                next_rise = 1'b1;                      // R5
            end
            else
                next_pcnt = pcnt + 8'h01;
        end
    end

    // The pin is foreign to clk, so only s2 onward feeds logic.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            pcnt  <= 8'h00;
            cnt   <= 7'h00;
            rise  <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1    <= din;
            s2    <= s1;
            s3    <= s2;
            pcnt  <= next_pcnt;
            cnt   <= next_cnt;
            rise  <= next_rise;
            level <= (next_cnt != 7'h00);
        end
    end

endmodule : rtg_stretch

// ===== rtg_top.sv
// Readout trigger generator: event tables, partitions, word slotting and accounting.
// Summary of operation
// R1 - Stretch each primitive and add a post-event inhibit, both 8 to 500 ns.
// R2 - No further event is accepted while the inhibit window is open.
// R3 - Tag each event by its earliest primitive to one clock and send it.
// R4 - Send one 16-bit word every word slot, with a quarter timing field.
// R5 - Every primitive is stretched and prescaled before it addresses a table.
// R6 - Main table is block memory giving two 11-bit event types.
// R7 - Host rewrites tables through 24-bit address, 32-bit data writes.
// R8 - Drop and flag on two triggers per slot, busy, or inhibit.
// R9 - Accumulate busy time and live time for efficiency.
// R10 - Loss to a higher-priority winner adds no dead time.
// R11 - Four partitions run in parallel, each with own table and data.
// R12 - Each partition selects 5 processor, 5 external, 3 asynchronous inputs.
// R13 - Partition types are 3 bits; zero means no event.
// R14 - Partition words carry 1011 in bits 15 to 12.
// R15 - Each partition owns one 3-bit field; no timing, no content word.
// R16 - A main strobe wins the slot over a partition strobe.
// R17 - Each main event leaves a readable data record.
// R18 - Each partition leaves its own readable event record.
// R19 - Flash reload at power-up is intended but not built.
// R20 - Old table stays in use until a reload is committed; only the main table is banked, partition tables are written in place.
// R21 - The word slot is derived inside from the system clock.
// R22 - Main strobe holds the 2-bit quarter of the slot.
// R23 - Bits 9:8 select action: 01 first, 10 second, 11 sync plus first.
// R24 - An accepted main strobe goes out at fixed latency, top priority.
// R25 - A dead-time counter runs while busy or inhibited.
// R26 - Lower-priority requests in a slot are dropped and counted, never delayed.
`timescale 1ns/1ps
`include "rtg_params.svh"
module rtg_top
    import rtg_pkg::*;
(
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Trigger primitive pins and front-end status pins.
    input  wire rtg_prim_t             prim_in,
    input  wire logic                  busy,
    input  wire logic                  trg_inhibit,
    // Settings.
    input  wire logic [6:0]            stretch_cyc,
    input  wire logic [6:0]            inhibit_cyc,
    input  wire logic [2:0][7:0]       prescale,
    input  wire rtg_psel_t [3:0]       psel,
    // Table writes.
    input  wire logic                  tbl_wr,
    input  wire logic [23:0]           tbl_addr,
    input  wire logic [31:0]           tbl_data,
    input  wire logic                  tbl_commit,
    // Trigger words.
    output logic [15:0]                trig_word,
    output logic                       word_strobe,
    output logic                       collision,
    // Event data and accounting.
    output rtg_evt_t                   evt,
    output logic                       evt_valid,
    output rtg_pevt_t [3:0]            pevt,
    output rtg_stat_t                  stat,
    output logic                       active_bank
);

    // ****************************************************************
    // Input conditioning
    // ****************************************************************
    rtg_prim_t   lvl, rise;
    logic [6:0]  st_len, inh_len;
    logic        bs1, bs2, is1, is2;

    assign st_len  = rtg_clamp(stretch_cyc);
    assign inh_len = rtg_clamp(inhibit_cyc);

    // One stretcher per primitive; the prescale is shared per group.
    for (genvar i = 0; i < 75; i++)
    begin : g_prim
        rtg_stretch u_stretch (
            .clk      (clk),
            .rst_n    (rst_n),
            .din      (prim_in[i]),
            .len      (st_len),
            .prescale (prescale[(i < 30) ? 0 : ((i < 60) ? 1 : 2)]),
            .level    (lvl[i]),
            .rise     (rise[i])
        );
    end

    // Status pins are asynchronous and pass two flip-flops.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bs1 <= 1'b0;
            bs2 <= 1'b0;
            is1 <= 1'b0;
            is2 <= 1'b0;
        end
        else
        begin
            bs1 <= busy;
            bs2 <= bs1;
            is1 <= trg_inhibit;
            is2 <= is1;
        end
    end

    // ****************************************************************
    // Partition input selection
    // ****************************************************************
    logic [3:0][12:0] paddr;
    logic [3:0]       prise;
    logic [31:0]      pv, pr, ev, er;
    logic [15:0]      av, ar;

    // Out-of-range indices select a zero input rather than an unknown.
    always_comb
    begin
        pv = {2'h0, lvl.proc};
        pr = {2'h0, rise.proc};
        ev = {2'h0, lvl.ext};
        er = {2'h0, rise.ext};
        av = {1'h0, lvl.asy};
        ar = {1'h0, rise.asy};
        for (int p = 0; p < 4; p++)
        begin
            prise[p] = 1'b0;
            for (int k = 0; k < 5; k++)
            begin
                paddr[p][k]     = pv[psel[p].proc[k]];              // R12
                paddr[p][5 + k] = ev[psel[p].ext[k]];
                prise[p]        = prise[p] | pr[psel[p].proc[k]] | er[psel[p].ext[k]];
            end
            for (int k = 0; k < 3; k++)
            begin
                paddr[p][10 + k] = av[psel[p].asy[k]];
                prise[p]         = prise[p] | ar[psel[p].asy[k]];
            end
        end
    end

    // ****************************************************************
    // Lookup tables
    // ****************************************************************
    // Two main banks let software fill one while the other triggers.
    logic [21:0]     main_tbl [0:2047];
    logic [2:0]      part_tbl [0:32767];
    logic [21:0]     lut_q;
    logic [3:0][2:0] ptq;

    // A future flash loader would drive this same write port.            R19
    always_ff @(posedge clk)
    begin
        if (tbl_wr && tbl_addr[23:20] == `RTG_SEL_MAIN)
            main_tbl[{~active_bank, tbl_addr[9:0]}] <= tbl_data[21:0];   // R7
        if (tbl_wr && tbl_addr[23:20] >= `RTG_SEL_P1 && tbl_addr[23:20] <= `RTG_SEL_P4)
            part_tbl[{2'(tbl_addr[23:20] - `RTG_SEL_P1), tbl_addr[12:0]}] <= tbl_data[2:0];
        lut_q <= main_tbl[{active_bank, rtg_fold(lvl)}];               // R6
        for (int p = 0; p < 4; p++)
            ptq[p] <= part_tbl[{2'(p), paddr[p]}];                     // R11
    end

    // ****************************************************************
    // Slot decision and word generation
    // ****************************************************************
    logic [13:0]     tstamp, next_tstamp;
    logic            seen, next_seen;
    logic [1:0]      quad, next_quad;
    logic [3:0]      pseen, next_pseen;
    logic [6:0]      inh_cnt, next_inh_cnt;
    logic [15:0]     next_word;
    logic            next_collision, next_evt_valid, next_bank;
    rtg_evt_t        next_evt;
    rtg_pevt_t [3:0] next_pevt;
    rtg_stat_t       next_stat;
    logic            slot_end, blocked, hit, req_a, req_b, part_req, main_sent;
    logic [10:0]     ta, tb;
    logic [11:0]     pword;

    // The slot closes at quarter 0 so the table output of the previous
    // quarter 3 is already registered; this fixes the strobe latency.
    assign slot_end = (tstamp[1:0] == 2'h0);                           // R21
    assign blocked  = bs2 | is2 | (inh_cnt != 7'h00);                  // R2
    assign hit      = |rise;
    assign ta       = lut_q[10:0];
    assign tb       = lut_q[21:11];
    assign req_a    = seen && ta[9:8] != `RTG_ACT_NONE;                // R23
    assign req_b    = seen && tb[9:8] != `RTG_ACT_NONE;

    always_comb
    begin
        next_tstamp    = tstamp + 14'h0001;
        next_seen      = seen | hit;
        next_quad      = (!seen && hit) ? tstamp[1:0] : quad;          // R3
        next_pseen     = pseen | prise;
        next_inh_cnt   = (inh_cnt != 7'h00) ? inh_cnt - 7'h01 : 7'h00;
        next_word      = trig_word;
        next_collision = 1'b0;
        next_evt_valid = 1'b0;
        next_evt       = evt;
        next_pevt      = pevt;
        next_stat      = stat;
        next_bank      = tbl_commit ? ~active_bank : active_bank;      // R20
        part_req       = 1'b0;
        main_sent      = 1'b0;
        for (int p = 0; p < 4; p++)
        begin
            pword[3*p +: 3] = pseen[p] ? ptq[p] : 3'h0;                // R15
            part_req        = part_req | (pword[3*p +: 3] != 3'h0);    // R13
        end
        // Dead time runs while blocked, live time in every other cycle.
        if (blocked)
            next_stat.dead = stat.dead + 32'h1;                        // R25
        else
            next_stat.live = stat.live + 32'h1;                        // R9
        if (slot_end)
        begin
            next_seen  = hit;
            next_quad  = tstamp[1:0];
            next_pseen = prise;
            next_word  = {`RTG_HDR_TIME, tstamp[13:2]};                // R4
            if (blocked && (seen || part_req))
                next_collision = 1'b1;                                 // R8
            else if (req_a || req_b)
            begin
                main_sent       = 1'b1;
                next_word       = {req_a ? `RTG_HDR_TRG_A : `RTG_HDR_TRG_B, quad,
                                   req_a ? ta[9:0] : tb[9:0]};         // R22 R24
                next_inh_cnt    = inh_len;                             // R1
                next_evt_valid  = 1'b1;
                next_evt.number = evt.number + 32'h1;                  // R17
                next_evt.time_tag = tstamp;
                next_evt.quad   = quad;
                next_evt.etype  = req_a ? ta : tb;
                next_evt.src_b  = !req_a;
                // Type B loses a shared slot and is counted, not delayed.
                if (req_a && req_b)
                begin
                    next_collision = 1'b1;                             // R8
                    next_stat.lost = stat.lost + 32'h1;                // R10 R26
                end
                if (part_req)
                    next_stat.part_lost = stat.part_lost + 32'h1;      // R16 R26
            end
            if (!blocked && !main_sent && part_req)
            begin
                next_word = {`RTG_HDR_PART, pword};                    // R14
                for (int p = 0; p < 4; p++)
                    if (pword[3*p +: 3] != 3'h0)
                    begin
                        next_pevt[p].count = pevt[p].count + 32'h1;    // R18
                        next_pevt[p].etype = pword[3*p +: 3];
                    end
            end
        end
    end

    // Slot state registers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tstamp      <= 14'h0000;
            seen        <= 1'b0;
            quad        <= 2'h0;
            pseen       <= 4'h0;
            inh_cnt     <= 7'h00;
            trig_word   <= {`RTG_HDR_TIME, 12'h000};
            word_strobe <= 1'b0;
            collision   <= 1'b0;
            evt         <= '0;
            evt_valid   <= 1'b0;
            pevt        <= '0;
            stat        <= '0;
            active_bank <= 1'b0;
        end
        else
        begin
            tstamp      <= next_tstamp;
            seen        <= next_seen;
            quad        <= next_quad;
            pseen       <= next_pseen;
            inh_cnt     <= next_inh_cnt;
            trig_word   <= next_word;
            word_strobe <= slot_end;
            collision   <= next_collision;
            evt         <= next_evt;
            evt_valid   <= next_evt_valid;
            pevt        <= next_pevt;
            stat        <= next_stat;
            active_bank <= next_bank;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_word_rate: assert property (word_strobe |=> !word_strobe [*3] ##1 word_strobe) // R4
        else $error("Word strobe not every fourth cycle.");
    a_veto_open: assert property ((slot_end && inh_cnt != 7'h00) |=> !evt_valid) // R2
        else $error("Event accepted inside inhibit window.");
    a_quad_field: assert property (evt_valid |-> trig_word[11:10] == evt.quad) // R3
        else $error("Quarter field differs from event tag.");
    a_part_fields: assert property ((word_strobe && trig_word[15:12] == `RTG_HDR_PART)
        |-> trig_word[11:0] != 12'h000) // R15
        else $error("Partition word without any partition type.");
    a_busy_drop: assert property ((slot_end && bs2 && seen) |=> collision && !evt_valid) // R8
        else $error("Busy slot not dropped and flagged.");
    a_dead_run: assert property (blocked |=> stat.dead == $past(stat.dead) + 32'h1) // R25
        else $error("Dead time not counted while blocked.");
    a_pair_live: assert property ((collision && evt_valid) |-> stat.dead == $past(stat.dead)) // R10
        else $error("Priority loss added dead time.");
    a_main_first: assert property (evt_valid |-> trig_word[15:12] != `RTG_HDR_PART
        && trig_word[9:8] != `RTG_ACT_NONE) // R16
        else $error("Main strobe missing in its slot.");
    a_bank_hold: assert property (!tbl_commit |=> $stable(active_bank)) // R20
        else $error("Table bank changed without commit.");

    c_main_event: cover property (evt_valid);
    c_pair_lost: cover property (evt_valid && collision);
    c_part_word: cover property (word_strobe && trig_word[15:12] == `RTG_HDR_PART);
    c_busy_drop: cover property (collision && !evt_valid);

endmodule : rtg_top
